// >>> hw/dmp_pkg.sv
// Package for the external data memory port: widths, reset values, states, carriers.
// Assumes one core clock; the bank and page configuration arrives as plain inputs.
// Contract
// - Read strobe is asserted throughout every external data memory read access.
// - Write strobe is asserted throughout every external data memory write access.
// - Deasserted acknowledge adds wait states; access extends while acknowledge stays low.
// - Page boundary output asserts when an access enters a different configured page.
// - Float control asserted puts address, data, selects and strobes into high impedance.
// - Float control during an access halts execution; access stays uncompleted until released.
// - Bus request: finish current cycle, halt, float all memory outputs, assert grant.
// - Grant stays driven low for as long as bus request remains asserted.
// - On request release, grant deasserts, interface is driven again, execution resumes.
// - One access cycle per clock period; clock never stops or changes rate.
// - Reset puts the port in a known state, ready for the reset vector fetch.
// - Acknowledge and float control are synchronous; bus request and reset are asynchronous; the code samples reset synchronously on clk.
// - Address is 32 bits, data 40 bits; 32-bit values use data bits 39 to 8.
// - Four bank selects decode the address against configured banks; may assert early.
package dmp_pkg;

   localparam int DMP_ADDR_W = 32;
   localparam int DMP_DATA_W = 40;
   localparam int DMP_BANKS = 4;
   localparam int DMP_SHIFT_W = 5;
   localparam int DMP_WORD_LSB = 8;
   localparam int DMP_SYNC_STAGES = 2;

   localparam logic [DMP_ADDR_W-1:0] DMP_ADDR_RST = 32'h0000_0000;
   localparam logic [DMP_DATA_W-1:0] DMP_DATA_RST = 40'h00_0000_0000;
   localparam logic [DMP_BANKS-1:0] DMP_SEL_IDLE_N = 4'hf;
   localparam logic DMP_STROBE_IDLE_N = 1'b1;
   localparam logic DMP_GRANT_IDLE_N = 1'b1;

   typedef enum logic [1:0] {
      DMP_IDLE = 2'b00,
      DMP_ACCESS = 2'b01,
      DMP_GRANT = 2'b10
   } dmp_state_e;

   // Bank boundaries: bank 0 below bound[0], bank 1 below bound[1], bank 2 below bound[2], else bank 3
   typedef struct packed {
      logic [DMP_BANKS-2:0][DMP_ADDR_W-1:0] bank_bound;
      logic [DMP_SHIFT_W-1:0] page_shift;
   } dmp_cfg_s;

   typedef struct packed {
      logic write;
      logic [DMP_ADDR_W-1:0] addr;
      logic [DMP_DATA_W-1:0] wdata;
   } dmp_req_s;

endpackage

// >>> hw/dmp_port.sv
// External data memory port: strobes, bank selects, wait states, page flag, float and bus grant.
// Assumes core requests and the ack/float pins are synchronous to clk; bus request is asynchronous.
`timescale 1ns/1ps
module dmp_port import dmp_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire dmp_cfg_s cfg,
   input wire logic req_valid,
   input wire dmp_req_s req,
   output logic req_ready,
   output logic [DMP_DATA_W-1:0] rdata,
   output logic rdata_valid,
   output logic core_halt,
   output logic [DMP_ADDR_W-1:0] dmem_addr,
   output logic [DMP_DATA_W-1:0] dmem_data_out,
   input wire logic [DMP_DATA_W-1:0] dmem_data_in,
   output logic dmem_data_oe,
   output logic dmem_bus_oe,
   output logic [DMP_BANKS-1:0] dmem_bank_select_n,
   output logic dmem_read_strobe_n,
   output logic dmem_write_strobe_n,
   output logic dmem_page_cross,
   input wire logic dmem_acknowledge,
   input wire logic dmem_float_control_n,
   input wire logic bus_request_in_n,
   output logic bus_grant_out_n
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic [DMP_BANKS-1:0] bank_decode(input logic [DMP_ADDR_W-1:0] a,
                                                        input dmp_cfg_s c);
      logic [DMP_BANKS-1:0] onehot;
      onehot = 4'h8;
      if (a < c.bank_bound[0])
         onehot = 4'h1;
      else if (a < c.bank_bound[1])
         onehot = 4'h2;
      else if (a < c.bank_bound[2])
         onehot = 4'h4;
      return onehot;
   endfunction

   function automatic logic [DMP_ADDR_W-1:0] page_of(input logic [DMP_ADDR_W-1:0] a,
                                                     input dmp_cfg_s c);
      return a >> c.page_shift;
   endfunction

   // ----------------------------------------------------------------
   // State and signals
   // ----------------------------------------------------------------
   dmp_state_e state, next_state;
   logic br_sync_n;
   logic br_active;
   logic floated;
   logic acc_write;
   logic page_valid;
   logic [DMP_ADDR_W-1:0] last_page;
   wire logic start_acc;
   wire logic acc_done;
   wire logic new_page;
   wire logic [DMP_BANKS-1:0] sel_early;

   // Bus request is asynchronous and only its synchronised copy is used
   dmp_sync #(
      .RST_VAL(1'b1)
   ) u_br_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .async_in(bus_request_in_n),
      .sync_out(br_sync_n)
   );

   assign br_active = !br_sync_n;
   assign floated = !dmem_float_control_n;

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   // New access only when idle and no bus request is pending
   assign req_ready = (state == DMP_IDLE) && !br_active && !sys_rst;
   assign start_acc = ce && req_valid && req_ready;
   // Access completes only with acknowledge high and the bus not floated
   assign acc_done = ce && (state == DMP_ACCESS) && dmem_acknowledge && !floated;
   assign new_page = !page_valid || (page_of(req.addr, cfg) != last_page);
   assign sel_early = bank_decode(req.addr, cfg);

   always_comb begin
      next_state = state;
      case (state)
         DMP_IDLE: begin
            if (br_active)
               next_state = DMP_GRANT;
            else if (start_acc)
               next_state = DMP_ACCESS;
         end
         DMP_ACCESS: begin
            if (acc_done)
               next_state = DMP_IDLE;
         end
         DMP_GRANT: begin
            if (!br_active)
               next_state = DMP_IDLE;
         end
         default: next_state = DMP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         state <= DMP_IDLE;
      else if (ce)
         state <= next_state;
   end

   // ----------------------------------------------------------------
   // Pin registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dmem_addr <= DMP_ADDR_RST;
         dmem_data_out <= DMP_DATA_RST;
         acc_write <= 1'b0;
         dmem_bank_select_n <= DMP_SEL_IDLE_N;
         dmem_read_strobe_n <= DMP_STROBE_IDLE_N;
         dmem_write_strobe_n <= DMP_STROBE_IDLE_N;
      end else if (ce) begin
         if (start_acc) begin
            dmem_addr <= req.addr;
            dmem_data_out <= req.wdata;
            acc_write <= req.write;
            dmem_bank_select_n <= ~sel_early;
            dmem_read_strobe_n <= req.write;
            dmem_write_strobe_n <= !req.write;
         end else if (acc_done) begin
            dmem_bank_select_n <= DMP_SEL_IDLE_N;
            dmem_read_strobe_n <= DMP_STROBE_IDLE_N;
            dmem_write_strobe_n <= DMP_STROBE_IDLE_N;
         end
      end
   end

   // Page flag stands for the whole access that entered a new page
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         last_page <= DMP_ADDR_RST;
         page_valid <= 1'b0;
         dmem_page_cross <= 1'b0;
      end else if (ce) begin
         if (start_acc) begin
            last_page <= page_of(req.addr, cfg);
            page_valid <= 1'b1;
            dmem_page_cross <= new_page;
         end else if (acc_done)
            dmem_page_cross <= 1'b0;
      end
   end

   // Read data captured on the completing edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata <= DMP_DATA_RST;
         rdata_valid <= 1'b0;
      end else if (ce) begin
         rdata_valid <= acc_done && !acc_write;
         if (acc_done && !acc_write)
            rdata <= dmem_data_in;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         bus_grant_out_n <= DMP_GRANT_IDLE_N;
      else if (ce)
         bus_grant_out_n <= !(next_state == DMP_GRANT);
   end

   // ----------------------------------------------------------------
   // Output enables and halt
   // ----------------------------------------------------------------
   assign dmem_bus_oe = !floated && (state != DMP_GRANT) && !sys_rst;
   assign dmem_data_oe = dmem_bus_oe && (state == DMP_ACCESS) && acc_write;
   assign core_halt = (state == DMP_GRANT) || ((state == DMP_ACCESS) && floated);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking dmp_cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence acc_waiting;
      ce && (state == DMP_ACCESS) && !dmem_acknowledge;
   endsequence

   sequence acc_finishing;
      ce && (state == DMP_ACCESS) && dmem_acknowledge && !floated;
   endsequence

   sequence grant_seen;
      ce && (state == DMP_IDLE) && br_active;
   endsequence

   read_strobe_a: assert property (
      (state == DMP_ACCESS) && !acc_write |-> !dmem_read_strobe_n && dmem_write_strobe_n)
      else $error("read strobe not asserted during read access");
   write_strobe_a: assert property (
      (state == DMP_ACCESS) && acc_write |-> !dmem_write_strobe_n && dmem_read_strobe_n)
      else $error("write strobe not asserted during write access");
   idle_strobe_a: assert property (
      (state != DMP_ACCESS) |-> dmem_read_strobe_n && dmem_write_strobe_n)
      else $error("strobe asserted outside an access");
   wait_state_a: assert property (
      acc_waiting |=> (state == DMP_ACCESS) && $stable(dmem_addr))
      else $error("access ended without acknowledge");
   ack_finish_a: assert property (
      acc_finishing |=> (state == DMP_IDLE) && dmem_read_strobe_n && dmem_write_strobe_n)
      else $error("acknowledged access did not complete");
   float_pins_a: assert property (
      floated |-> !dmem_bus_oe && !dmem_data_oe)
      else $error("outputs driven while float control asserted");
   float_halt_a: assert property (
      ce && (state == DMP_ACCESS) && floated |-> core_halt ##1 (state == DMP_ACCESS) && !rdata_valid)
      else $error("floated access completed or core not halted");
   grant_enter_a: assert property (
      grant_seen |=> !bus_grant_out_n && !dmem_bus_oe && core_halt)
      else $error("bus request not granted");
   grant_wait_a: assert property (
      (state == DMP_ACCESS) |-> bus_grant_out_n)
      else $error("grant given before the access finished");
   grant_hold_a: assert property (
      (state == DMP_GRANT) && br_active |-> !bus_grant_out_n)
      else $error("grant dropped while request held");
   grant_release_a: assert property (
      ce && (state == DMP_GRANT) && !br_active |=> bus_grant_out_n && (state == DMP_IDLE))
      else $error("grant not released after request");
   page_flag_a: assert property (
      start_acc && new_page |=> dmem_page_cross)
      else $error("page crossing not flagged");
   bank_sel_a: assert property (
      (state == DMP_ACCESS) |-> $onehot(~dmem_bank_select_n))
      else $error("bank select not one-hot during access");
   sync_delay_a: assert property (
      ce && !bus_request_in_n ##1 ce && !bus_request_in_n |=> br_active)
      else $error("bus request synchroniser latency wrong");

endmodule // dmp_port

// >>> hw/dmp_sync.sv
// Two-stage level synchroniser with clock enable.
// Assumes the input is asynchronous to clk; only the second stage is read outside.
`timescale 1ns/1ps
module dmp_sync import dmp_pkg::*; #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic async_in,
   output logic sync_out
);

   logic stage1;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1 <= RST_VAL;
         sync_out <= RST_VAL;
      end else if (ce) begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // dmp_sync

// >>> testbench/dmp_mem_model.sv
// External data memory model for the data memory port bench.
// Assumes the bench sets the wait count before each access; reset is synchronous.
`timescale 1ns/1ps
module dmp_mem_model import dmp_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] waits,
   input wire logic [DMP_ADDR_W-1:0] dmem_addr,
   input wire logic [DMP_DATA_W-1:0] dmem_data_out,
   input wire logic dmem_data_oe,
   input wire logic dmem_bus_oe,
   input wire logic dmem_read_strobe_n,
   input wire logic dmem_write_strobe_n,
   output logic [DMP_DATA_W-1:0] dmem_data_in,
   output logic dmem_acknowledge
);
   // ----------------------------------------
   // Wait states, storage and released data
   // ----------------------------------------
   logic [DMP_DATA_W-1:0] mem [256];
   logic [DMP_DATA_W-1:0] last;
   logic [3:0] cnt;
   logic active;
   assign active = !dmem_read_strobe_n || !dmem_write_strobe_n;
   // Ack low for the wait count, then high until the strobe drops
   assign dmem_acknowledge = (cnt >= waits);
   // Undriven data toggles every cycle so a stale word cannot pass
   assign dmem_data_in = (!dmem_read_strobe_n && dmem_bus_oe) ? mem[dmem_addr[11:4]] : ~last;
   always_ff @(posedge clk) begin
      if (sys_rst || !active) begin
         cnt <= 4'h0;
      end else if (cnt < waits) begin
         cnt <= cnt + 4'h1;
      end
      last <= sys_rst ? DMP_DATA_RST : dmem_data_in;
      if (!dmem_write_strobe_n && dmem_data_oe && dmem_acknowledge) begin
         mem[dmem_addr[11:4]] <= dmem_data_out;
      end
   end
endmodule // dmp_mem_model

// >>> testbench/testbench.sv
// Self-checking bench for the data memory port: access table, float and bus grant cases.
// Assumes the memory model answers on the far side; inputs change at the falling edge.
`timescale 1ns/1ps
module testbench import dmp_pkg::*;;
   typedef struct packed {
      logic wr;
      logic [31:0] addr;
      logic [39:0] data;
      logic [3:0] waits;
      logic [3:0] sel;
      logic page;
   } dmp_row_s;
   logic clk, sys_rst, ce, req_valid, req_ready, rdata_valid, core_halt, data_oe, bus_oe;
   logic rd_n, wr_n, page, ack, float_n, br_n, bg_n;
   logic [3:0] waits, sel_n;
   logic [31:0] addr;
   logic [39:0] rdata, dout, din;
   dmp_cfg_s cfg;
   dmp_req_s req;
   dmp_row_s rows [7];
   int n_fail = 0;
   int checks = 0;
   int n;
   dmp_port u_dmp_port (.clk(clk), .sys_rst(sys_rst), .ce(ce), .cfg(cfg), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid), .core_halt(core_halt), .dmem_addr(addr),
      .dmem_data_out(dout), .dmem_data_in(din), .dmem_data_oe(data_oe), .dmem_bus_oe(bus_oe),
      .dmem_bank_select_n(sel_n), .dmem_read_strobe_n(rd_n), .dmem_write_strobe_n(wr_n), .dmem_page_cross(page),
      .dmem_acknowledge(ack), .dmem_float_control_n(float_n), .bus_request_in_n(br_n), .bus_grant_out_n(bg_n));
   dmp_mem_model u_dmp_mem_model (.clk(clk), .sys_rst(sys_rst), .waits(waits), .dmem_addr(addr),
      .dmem_data_out(dout), .dmem_data_oe(data_oe), .dmem_bus_oe(bus_oe), .dmem_read_strobe_n(rd_n),
      .dmem_write_strobe_n(wr_n), .dmem_data_in(din), .dmem_acknowledge(ack));
   always #50 clk = ~clk;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic report_and_stop();
      if (n_fail == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic bound(input int k);
      if (k >= 50) begin
         n_fail++;
         report_and_stop();
      end
   endtask
   // Float is held for flt cycles from the first strobe cycle
   task automatic do_access(input dmp_row_s r, input int flt);
      int k;
      @(negedge clk);
      waits = r.waits;
      req_valid = 1'b1;
      req = '{r.wr, r.addr, r.data};
      k = 0;
      while (req_ready !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
      bound(k);
      @(negedge clk);
      req_valid = 1'b0;
      chk("select", 40'(r.sel), 40'(sel_n));
      chk("page", 40'(r.page), 40'(page));
      chk("address", 40'(r.addr), 40'(addr));
      chk("idle strobe", 40'h1, 40'(r.wr ? rd_n : wr_n));
      chk("data drive", 40'(r.wr), 40'(data_oe));
      chk("bus drive", 40'h1, 40'(bus_oe));
      k = 0;
      while ((r.wr ? wr_n : rd_n) === 1'b0 && k < 50) begin
         k++;
         float_n = (k > flt);
         if (k <= flt) begin
            #1;
            chk("float bus", 40'h0, 40'(bus_oe));
            chk("float data", 40'h0, 40'(data_oe));
            chk("halt", 40'h1, 40'(core_halt));
         end
         @(negedge clk);
      end
      bound(k);
      chk("strobe cycles", 40'(1 + ((flt > r.waits) ? flt : r.waits)), 40'(k));
      if (!r.wr) begin
         chk("read valid", 40'h1, 40'(rdata_valid));
         chk("read data", r.data, rdata);
      end else begin
         chk("write no data", 40'h0, 40'(rdata_valid));
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      ce = 1'b1;
      req_valid = 1'b0;
      req = '0;
      waits = 4'h0;
      float_n = 1'b1;
      br_n = 1'b1;
      cfg = '{bank_bound: '{32'h300, 32'h200, 32'h100}, page_shift: 5'h04};
      rows = '{'{1'b1, 32'h10, 40'h12_3456_7800, 4'h0, 4'he, 1'b1},
         '{1'b0, 32'h10, 40'h12_3456_7800, 4'h2, 4'he, 1'b0},
         '{1'b1, 32'h150, 40'haa_bbcc_dd01, 4'h1, 4'hd, 1'b1}, '{1'b1, 32'h2ff, 40'h01_0203_0405, 4'h0, 4'hb, 1'b1},
         '{1'b0, 32'h150, 40'haa_bbcc_dd01, 4'h0, 4'hd, 1'b1}, '{1'b1, 32'h300, 40'hff_0000_ff00, 4'h3, 4'h7, 1'b1},
         '{1'b0, 32'h30f, 40'hff_0000_ff00, 4'h1, 4'h7, 1'b0}};
      repeat (6) @(negedge clk);
      chk("reset strobes", 40'h3, 40'({rd_n, wr_n}));
      chk("reset grant", 40'h1, 40'(bg_n));
      chk("reset select", 40'hf, 40'(sel_n));
      chk("reset drive", 40'h0, 40'({bus_oe, req_ready}));
      sys_rst = 1'b0;
      foreach (rows[i]) do_access(rows[i], 0);
      do_access('{1'b0, 32'h2ff, 40'h01_0203_0405, 4'h1, 4'hb, 1'b1}, 3);
      @(negedge clk);
      br_n = 1'b0;
      n = 0;
      while (bg_n !== 1'b0 && n < 50) begin
         @(negedge clk);
         n++;
      end
      bound(n);
      chk("grant delay", 40'h3, 40'(n));
      repeat (5) begin
         chk("grant held", 40'h0, 40'(bg_n));
         chk("granted bus", 40'h0, 40'({bus_oe, req_ready}));
         chk("granted halt", 40'h1, 40'(core_halt));
         @(negedge clk);
      end
      // Clock enable low freezes the synchroniser, so the grant must stay
      ce = 1'b0;
      br_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("frozen grant", 40'h0, 40'({bg_n, bus_oe}));
      ce = 1'b1;
      n = 0;
      while (bg_n !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      bound(n);
      chk("release delay", 40'h3, 40'(n));
      chk("bus back", 40'h1, 40'(bus_oe));
      float_n = 1'b0;
      #1;
      chk("idle float", 40'h0, 40'(bus_oe));
      @(negedge clk);
      float_n = 1'b1;
      do_access('{1'b0, 32'h10, 40'h12_3456_7800, 4'h0, 4'he, 1'b1}, 0);
      // Bus request inside a stretched write waits for the write to end
      @(negedge clk);
      waits = 4'h6;
      req_valid = 1'b1;
      req = '{1'b1, 32'h1c, 40'h55_0000_0055};
      @(negedge clk);
      req_valid = 1'b0;
      br_n = 1'b0;
      n = 0;
      while (wr_n === 1'b0 && n < 50) begin
         chk("grant in access", 40'h1, 40'(bg_n));
         @(negedge clk);
         n++;
      end
      chk("stretched strobe", 40'h7, 40'(n));
      @(negedge clk);
      chk("grant after access", 40'h1, 40'({bg_n, bus_oe, wr_n}));
      // Reset in mid-run, taken while the bus is granted
      br_n = 1'b1;
      sys_rst = 1'b1;
      @(negedge clk);
      chk("mid reset", 40'hfe0, 40'({bg_n, rd_n, wr_n, sel_n, page, rdata_valid, bus_oe, req_ready, core_halt}));
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      // Same page as before reset, yet the first access flags a crossing
      do_access('{1'b0, 32'h10, 40'h55_0000_0055, 4'h0, 4'he, 1'b1}, 0);
      report_and_stop();
   end
endmodule // testbench
